//--- verilog/sleep_wake_watchdog_control.sv
// Sleep, wake-up and watchdog controller for the processor core.
// Summary of operation
// - watchdog counter doubles as power-up delay
// - plain timer mode counts the device clock
// - software cannot read or write counters
// - plain timer overflows after 65536 clocks
// - plain timer overflow clears timeout, no reset
// - clear-watchdog instruction sets timeout flag
// - plain timer stops counting during sleep
// - sleep enters power-down, clears enabled watchdog
// - sleep clears powerdown flag, sets timeout flag
// - sleep stops oscillator driver, pins hold
// - watchdog reset never drives master clear
// - reset events and enabled interrupts wake
// - only listed peripheral interrupts can wake
// - reset wakes reset, interrupt wakes resume
// - powerdown flag set on power-up
// - watchdog reset clears timeout flag
// - sleep instruction prefetches next address
// - wake needs source enable, ignores global disable
// - run next instruction, vector if enabled
// - pending enabled interrupt at sleep wakes immediately
// - watchdog counter cleared on every wake
// - crystal modes wait 1024 clocks on wake
// - postscale select encodes enable and ratio
// - enabled watchdog overflow resets the device
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "swwd_defs.svh"

module sleep_wake_watchdog_control #(
  parameter int WDT_CNT_W = `TMR_CNT_W // Watchdog counter width.
) (
  input wire logic sys_clk,                      // System clock, 200 MHz.
  input wire logic reset_n,                      // Power-on reset, active low.
  input wire swwd_pkg::bus_req_t bus_req,        // Software port request.
  output logic [31:0] rd_data,                   // Read data, cycle after strobe.
  input wire logic sleep_instr,                  // Sleep instruction executes.
  input wire logic clear_wdt_instr,              // Clear-watchdog instruction executes.
  input wire logic global_int_disable,           // Global interrupt disable bit.
  input wire swwd_pkg::int_src_t int_src,        // Interrupt flags and enables.
  input wire logic wdt_rc_clk,                   // Watchdog RC oscillator pin.
  input wire logic master_clear_n,               // Master clear pin level.
  input wire logic brownout_n,                   // Brown-out detector, low in fault.
  output logic master_clear_out,                 // Master clear pin drive value.
  output logic master_clear_oe,                  // Master clear pin drive enable.
  output swwd_pkg::core_ctl_t core_ctl,          // Controls to core and pads.
  output logic timeout_flag,                     // Time-out status flag.
  output logic powerdown_flag                    // Power-down status flag.
);
  import swwd_pkg::*;

  // ==========================================================
  // Declarations.
  logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r; // Three-stage pin synchroniser.
  logic [2:0] pin_stab_r; // Pin levels once stages two and three agree.
  logic rc_prev_r; // Previous stable RC clock level.
  logic rc_rise; // One-cycle pulse on a watchdog RC clock rising edge.
  logic mclr_req, bor_req; // Reset requests from pins.
  logic [3:0] cfg_r; // Oscillator mode and postscale select.
  logic [1:0] osc_mode, ps_sel; // Configuration fields.
  logic wdt_on, xtal; // Watchdog enabled, crystal-type oscillator.
  state_t st_r, st_nxt; // Controller state.
  logic [WDT_CNT_W-1:0] cnt_r; // Watchdog counter.
  logic [`PS_W-1:0] ps_r; // Postscaler.
  logic [`PS_W-1:0] ps_lim; // Postscaler terminal value in use.
  logic tick, cnt_wrap, ps_hit; // Counter step, wrap and full overflow.
  logic wdt_ovf, tmr_ovf, power_up_delay_timer_done; // Overflow events.
  logic cnt_clr; // Clear counter and postscaler.
  logic pending; // Enabled wake-capable interrupt pending.
  logic sleep_go, wake_go, int_wake; // Sleep entry and wake events.
  logic [`OST_CNT_W-1:0] ost_r; // Start-up delay counter.
  logic ost_done; // Start-up delay complete.
  logic bor_seen_r, was_sleep_r, wake_int_r; // Reset and wake history.
  logic resume_go; // Execution resumes after an interrupt wake.

  // Postscaler terminal value for a postscale select code.
  function automatic logic [`PS_W-1:0] ps_limit(input logic [1:0] sel);
    case (sel)
      `PS_SEL_1: ps_limit = `PS_LIM_1;
      `PS_SEL_256: ps_limit = `PS_LIM_256;
      `PS_SEL_64: ps_limit = `PS_LIM_64;
      default: ps_limit = `PS_LIM_1;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers.
  // Three flops per pin; a level is taken once stages two and three agree.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= `PIN_RST;
      pin_s2_r <= `PIN_RST;
      pin_s3_r <= `PIN_RST;
    end else begin
      pin_s1_r <= {brownout_n, master_clear_n, wdt_rc_clk};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Stable level: follows when both late stages agree, else holds.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_stab_r <= `PIN_RST;
      rc_prev_r <= 1'b0;
    end else begin
      pin_stab_r <= (pin_s2_r & pin_s3_r) | (pin_stab_r & (pin_s2_r | pin_s3_r));
      rc_prev_r <= pin_stab_r[`PIN_RC];
    end
  end

  assign rc_rise = pin_stab_r[`PIN_RC] & ~rc_prev_r;
  assign mclr_req = ~pin_stab_r[`PIN_MCLR];
  assign bor_req = ~pin_stab_r[`PIN_BOR];

  // ==========================================================
  // Configuration decode.
  assign osc_mode = cfg_r[`CFG_OSC_LO +: 2];
  assign ps_sel = cfg_r[`CFG_PS_LO +: 2];
  assign wdt_on = (ps_sel != `PS_SEL_TMR);
  assign xtal = (osc_mode == `OSC_XT) || (osc_mode == `OSC_LF);

  // ==========================================================
  // Watchdog counter and postscaler.
  // Power-up delay and watchdog step on RC edges; plain timer mode steps
  // on the device clock and only while running, never in sleep.
  always_comb begin
    if (wdt_on || st_r == ST_POWER_UP_DELAY_TIMER) begin
      tick = rc_rise;
    end else begin
      tick = (st_r == ST_RUN);
    end
  end

  assign ps_lim = (st_r == ST_POWER_UP_DELAY_TIMER) ? `POWER_UP_DELAY_TIMER_PS_LIM : ps_limit(ps_sel);
  assign cnt_wrap = tick & (&cnt_r);
  assign ps_hit = cnt_wrap & (ps_r == ps_lim);
  assign wdt_ovf = ps_hit & wdt_on & (st_r == ST_RUN || st_r == ST_SLEEP);
  assign tmr_ovf = cnt_wrap & ~wdt_on & (st_r == ST_RUN);
  assign power_up_delay_timer_done = ps_hit & (st_r == ST_POWER_UP_DELAY_TIMER);

  // Clearing sources: reset state, enabled sleep, clear instruction, wake.
  assign cnt_clr = (st_r == ST_RST) | (sleep_go & wdt_on) |
                   (clear_wdt_instr & st_r == ST_RUN) | wake_go;

  // Counter steps on tick, postscaler on each counter wrap.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      ps_r <= '0;
    end else if (cnt_clr) begin
      cnt_r <= '0;
      ps_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1;
      if (cnt_wrap) begin
        ps_r <= (ps_r == ps_lim) ? '0 : ps_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Wake sources.
  // Only enabled, wake-capable sources count; global disable is ignored.
  assign pending = |(int_src.flag & int_src.enable & `WAKE_MASK);

  // ==========================================================
  // Controller state machine.
  // Reset pins override everything; watchdog overflow is reset-type.
  always_comb begin
    st_nxt = st_r;
    if (bor_req || mclr_req) begin
      st_nxt = ST_RST;
    end else begin
      case (st_r)
        ST_POWER_UP_DELAY_TIMER: begin
          if (power_up_delay_timer_done) begin
            st_nxt = xtal ? ST_OST : ST_RUN;
          end
        end
        ST_RUN: begin
          if (wdt_ovf) begin
            st_nxt = ST_RST;
          end else if (sleep_instr) begin
            st_nxt = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wdt_ovf) begin
            st_nxt = ST_RST;
          end else if (pending) begin
            st_nxt = xtal ? ST_OST : ST_RUN;
          end
        end
        ST_OST: begin
          if (ost_done) begin
            st_nxt = ST_RUN;
          end
        end
        ST_RST: begin
          if (bor_seen_r) begin
            st_nxt = ST_POWER_UP_DELAY_TIMER;
          end else if (xtal && was_sleep_r) begin
            st_nxt = ST_OST;
          end else begin
            st_nxt = ST_RUN;
          end
        end
        default: st_nxt = ST_POWER_UP_DELAY_TIMER;
      endcase
    end
  end

  assign sleep_go = (st_r == ST_RUN) && (st_nxt == ST_SLEEP);
  assign wake_go = (st_r == ST_SLEEP) && (st_nxt != ST_SLEEP);
  assign int_wake = wake_go && (st_nxt != ST_RST);
  assign resume_go = (int_wake && !xtal) || (st_r == ST_OST && ost_done && wake_int_r);

  // State register; power-on starts with the power-up delay.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_POWER_UP_DELAY_TIMER;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Reset and wake history that picks the exit path.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bor_seen_r <= 1'b0;
      was_sleep_r <= 1'b0;
      wake_int_r <= 1'b0;
    end else begin
      if (bor_req) begin
        bor_seen_r <= 1'b1;
      end else if (st_r == ST_RST && st_nxt != ST_RST) begin
        bor_seen_r <= 1'b0;
      end
      if (st_r == ST_SLEEP && st_nxt == ST_RST) begin
        was_sleep_r <= 1'b1;
      end else if (st_r == ST_RST && st_nxt != ST_RST) begin
        was_sleep_r <= 1'b0;
      end
      if (int_wake && xtal) begin
        wake_int_r <= 1'b1;
      end else if (st_r != ST_OST) begin
        wake_int_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Oscillator start-up delay, counted in device clocks.
  assign ost_done = (ost_r == `OSC_DONE_VAL);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ost_r <= '0;
    end else if (st_r != ST_OST) begin
      ost_r <= '0;
    end else if (!ost_done) begin
      ost_r <= ost_r + 1'b1;
    end
  end

  // ==========================================================
  // Status flags.
  // Overflow clearing wins over instruction setting in the same cycle.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_flag <= 1'b1;
    end else if (wdt_ovf || tmr_ovf) begin
      timeout_flag <= 1'b0;
    end else if ((clear_wdt_instr && st_r == ST_RUN) || sleep_go) begin
      timeout_flag <= 1'b1;
    end
  end

  // Power-down flag is set at power-up and by brown-out, cleared by sleep.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      powerdown_flag <= 1'b1;
    end else if (bor_req) begin
      powerdown_flag <= 1'b1;
    end else if (sleep_go) begin
      powerdown_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Core and pad controls, registered from the next state.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_ctl <= '0;
      core_ctl.device_reset <= 1'b1;
      core_ctl.osc_driver_en <= 1'b1;
    end else begin
      core_ctl.device_reset <= (st_nxt == ST_POWER_UP_DELAY_TIMER) || (st_nxt == ST_RST) ||
                               (st_nxt == ST_OST && !(wake_int_r || (int_wake && xtal)));
      core_ctl.core_hold <= (st_nxt == ST_OST);
      core_ctl.osc_driver_en <= (st_nxt != ST_SLEEP);
      core_ctl.io_hold <= (st_nxt == ST_SLEEP);
      core_ctl.in_sleep <= (st_nxt == ST_SLEEP);
      core_ctl.prefetch_next <= sleep_go;
      core_ctl.resume <= resume_go;
      core_ctl.take_vector <= resume_go && !global_int_disable;
    end
  end

  // The watchdog resets the core internally and never pulls the pin.
  assign master_clear_out = 1'b0;
  assign master_clear_oe = 1'b0;

  // ==========================================================
  // Software port.
  // Only configuration is writable; counters have no address at all.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= `CFG_RST;
    end else if (bus_req.wr && bus_req.addr == `REG_CONFIG) begin
      cfg_r <= bus_req.wdata[3:0];
    end
  end

  // Read data stand for one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= '0;
      if (bus_req.rd) begin
        case (bus_req.addr)
          `REG_STATUS: begin
            rd_data[`ST_PD_BIT] <= powerdown_flag;
            rd_data[`ST_TO_BIT] <= timeout_flag;
            rd_data[`ST_GID_BIT] <= global_int_disable;
            rd_data[`ST_SLP_BIT] <= (st_r == ST_SLEEP);
          end
          `REG_CONFIG: rd_data[3:0] <= cfg_r;
          default: rd_data <= '0;
        endcase
      end
    end
  end

endmodule // sleep_wake_watchdog_control
`default_nettype wire

//--- verilog/swwd_defs.svh
// Constants for the sleep, wake-up and watchdog controller.
`ifndef SWWD_DEFS_SVH
`define SWWD_DEFS_SVH
// ==========================================================
// Register map of the plain software port.
`define REG_STATUS 8'h00
`define REG_CONFIG 8'h04
`define CFG_RST 4'hf
// Configuration field positions: [1:0] oscillator, [3:2] postscale.
`define CFG_OSC_LO 0
`define CFG_PS_LO 2
// Status bit positions.
`define ST_PD_BIT 0
`define ST_TO_BIT 1
`define ST_GID_BIT 2
`define ST_SLP_BIT 3
// ==========================================================
// Oscillator mode and postscale select encodings.
`define OSC_EC 2'h3
`define OSC_XT 2'h2
`define OSC_RC 2'h1
`define OSC_LF 2'h0
`define PS_SEL_1 2'h3
`define PS_SEL_256 2'h2
`define PS_SEL_64 2'h1
`define PS_SEL_TMR 2'h0
`define PS_LIM_1 8'h00
`define PS_LIM_256 8'hff
`define PS_LIM_64 8'h3f
`define POWER_UP_DELAY_TIMER_PS_LIM 8'h00
// ==========================================================
// Counter widths and timing.
`define TMR_CNT_W 16
`define PS_W 8
`define OST_TOSC 1024
`define OST_CNT_W 11
// ==========================================================
// Synchronised pins: watchdog RC clock, master clear, brown-out.
`define PIN_RC 0
`define PIN_MCLR 1
`define PIN_BOR 2
`define PIN_RST 3'h6
// Interrupt sources; the low nine may wake the device.
`define NSRC 10
`define WAKE_MASK 10'h1ff
// Last count of the start-up delay, one less than its length in clocks.
`define OSC_DONE_VAL 11'h3ff
`endif

//--- verilog/swwd_pkg.sv
// Types shared by the sleep, wake-up and watchdog controller.
`default_nettype none
`include "swwd_defs.svh"
package swwd_pkg;
  // Software port request.
  typedef struct packed {
    logic [7:0] addr;   // Byte address.
    logic [31:0] wdata; // Write data.
    logic wr;           // Write strobe.
    logic rd;           // Read strobe.
  } bus_req_t;
  // Interrupt flags and enables from the sources.
  typedef struct packed {
    logic [`NSRC-1:0] flag;   // Pending flags.
    logic [`NSRC-1:0] enable; // Individual enables.
  } int_src_t;
  // Controls to the processor core and pads.
  typedef struct packed {
    logic device_reset;  // Core held in reset.
    logic core_hold;     // Core stalled for oscillator start-up.
    logic osc_driver_en; // Main oscillator driver on.
    logic io_hold;       // Pins keep their last state.
    logic in_sleep;      // Power-down state.
    logic prefetch_next; // Fetch the word after the sleep instruction.
    logic resume;        // Execution resumes after an interrupt wake.
    logic take_vector;   // Branch to the vector after the next instruction.
  } core_ctl_t;
  // Controller states.
  typedef enum logic [2:0] {
    ST_POWER_UP_DELAY_TIMER, ST_RUN, ST_SLEEP, ST_OST, ST_RST
  } state_t;
endpackage
`default_nettype wire

//--- dv/swwd_checker_assertions.sv
// Port checker for the sleep, wake-up and watchdog controller.
`timescale 1ns/100ps
`default_nettype none
module swwd_checker #(
  parameter int WDT_CNT_W = 16 // Watchdog counter width.
) (
  input wire logic sys_clk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire swwd_pkg::bus_req_t bus_req, // Software port.
  input wire logic [31:0] rd_data, // Read data.
  input wire logic global_int_disable, // Global disable.
  input wire logic master_clear_oe, // Pin drive enable.
  input wire swwd_pkg::core_ctl_t core_ctl, // Core controls.
  input wire logic timeout_flag, // Time-out flag.
  input wire logic powerdown_flag // Power-down flag.
);
  import swwd_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Helper: length of the current start-up hold in cycles.
  logic [11:0] hold_cnt_r; // Cycles held so far.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_r <= 12'h000;
    end else begin
      hold_cnt_r <= core_ctl.core_hold ? hold_cnt_r + 12'h001 : 12'h000;
    end
  end
  // ==========================================================
  // Assertions.
  mclr_undriven_a:
    assert property (!master_clear_oe) else $error("master clear pin driven");
  sleep_entry_a:
    assert property ($rose(core_ctl.in_sleep) |-> !powerdown_flag && timeout_flag && core_ctl.prefetch_next
      ##1 !core_ctl.prefetch_next) else $error("sleep entry flags wrong");
  sleep_pads_a:
    assert property (core_ctl.in_sleep |-> !core_ctl.osc_driver_en && core_ctl.io_hold)
    else $error("oscillator or pins wrong in sleep");
  vector_gate_a:
    assert property (core_ctl.resume |-> core_ctl.take_vector == !$past(global_int_disable))
    else $error("vector branch wrong");
  pd_clear_a:
    assert property ($fell(powerdown_flag) |-> core_ctl.in_sleep) else $error("powerdown flag cleared outside sleep");
  rd_idle_a:
    assert property (!$past(bus_req.rd) |-> rd_data == 32'h0) else $error("read data outside its cycle");
  sleep_exit_a:
    assert property ($fell(core_ctl.in_sleep) |-> core_ctl.resume || core_ctl.core_hold || core_ctl.device_reset)
    else $error("sleep left without resume or reset");
  hold_span_a:
    assert property ($fell(core_ctl.core_hold) |-> hold_cnt_r inside {[1024:1025]}) else $error("start-up hold length");
  resume_pulse_a:
    assert property (core_ctl.resume |=> !core_ctl.resume) else $error("resume longer than one cycle");
endmodule // swwd_checker
`default_nettype wire

//--- dv/swwd_far_side.sv
// Far-side model: watchdog RC oscillator and reset pins.
`timescale 1ns/100ps
`default_nettype none
module swwd_far_side #(
  parameter int RC_HALF = 20 // RC half period in ns.
) (
  input wire logic rc_run, // Oscillator runs while high.
  input wire logic mclr_level, // Level of the external reset source.
  input wire logic master_clear_out, // Device drive value.
  input wire logic master_clear_oe, // Device drive enable.
  output logic wdt_rc_clk, // RC oscillator output.
  output logic master_clear_n, // Resolved master clear wire.
  output logic brownout_n // Brown-out detector, never in fault here.
);
  // The oscillator may be stopped to model a very slow RC clock.
  initial wdt_rc_clk = 1'b0;
  always #(RC_HALF) if (rc_run) wdt_rc_clk = ~wdt_rc_clk;
  // The wire follows the device only while it drives the pin.
  assign master_clear_n = master_clear_oe ? master_clear_out : mclr_level;
  assign brownout_n = 1'b1;
endmodule // swwd_far_side
`default_nettype wire

//--- dv/tb.sv
// Self-checking testbench for the sleep, wake-up and watchdog controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import swwd_pkg::*;
  localparam int W = 4; // Shortened counter width.
  localparam int RCP = 8; // RC period in clock cycles.
  logic sys_clk = 1'b0; // Clock.
  logic reset_n = 1'b0; // Reset.
  bus_req_t bus_req = '0; // Software port.
  logic sleep_instr = 1'b0; // Sleep instruction.
  logic clear_wdt_instr = 1'b0; // Clear-watchdog instruction.
  logic global_int_disable = 1'b0; // Global disable.
  int_src_t int_src = '0; // Interrupt sources.
  logic rc_run = 1'b1; // RC oscillator runs.
  logic mclr_level = 1'b1; // External reset source level.
  logic [31:0] rd_data; // Read data.
  logic wdt_rc_clk, master_clear_n, brownout_n, master_clear_out, master_clear_oe; // Pins.
  core_ctl_t core_ctl; // Core controls.
  logic timeout_flag, powerdown_flag; // Status flags.
  int fails = 0; // Mismatches.
  int num_checks = 0; // Comparisons.
  always #2.5 sys_clk = ~sys_clk;
  sleep_wake_watchdog_control #(.WDT_CNT_W(W)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
    .rd_data(rd_data), .sleep_instr(sleep_instr), .clear_wdt_instr(clear_wdt_instr),
    .global_int_disable(global_int_disable), .int_src(int_src), .wdt_rc_clk(wdt_rc_clk),
    .master_clear_n(master_clear_n), .brownout_n(brownout_n), .master_clear_out(master_clear_out),
    .master_clear_oe(master_clear_oe), .core_ctl(core_ctl), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag));
  swwd_far_side #(.RC_HALF(RCP * 5 / 2)) far (.rc_run(rc_run), .mclr_level(mclr_level),
    .master_clear_out(master_clear_out), .master_clear_oe(master_clear_oe), .wdt_rc_clk(wdt_rc_clk),
    .master_clear_n(master_clear_n), .brownout_n(brownout_n));
  // ==========================================================
  // Shared tasks.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 chk(what, exp, rd_data);
  endtask
  // Issues one instruction: sleep when slp is high, else clear-watchdog.
  task automatic instr(input logic slp);
    @(posedge sys_clk);
    if (slp) sleep_instr <= 1'b1; else clear_wdt_instr <= 1'b1;
    @(posedge sys_clk);
    sleep_instr <= 1'b0;
    clear_wdt_instr <= 1'b0;
    #1;
  endtask
  // Raises the given enabled sources, counts cycles up to the resume pulse and returns the vector bit beside it.
  task automatic wake(input logic [9:0] src, output int n, output logic tv);
    @(posedge sys_clk);
    int_src <= '{flag: src, enable: src};
    n = 0;
    while (core_ctl.resume !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    tv = core_ctl.take_vector;
    chk("awake", 0, core_ctl.in_sleep);
    @(posedge sys_clk);
    int_src <= '0;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_powerup();
    int n;
    repeat (100) @(posedge sys_clk);
    #1 chk("power-up delay", 1, core_ctl.device_reset);
    for (n = 0; n < 300 && core_ctl.device_reset !== 1'b0; n++) @(posedge sys_clk);
    #1 chk("power-up done", 0, core_ctl.device_reset);
    rc_run <= 1'b0;
    bus_rd(8'h00, 32'h3, "status");
    bus_rd(8'h04, 32'hf, "config");
    bus_rd(8'h08, 32'h0, "no counter access");
    bus_wr(8'h00, 32'h0);
    bus_rd(8'h00, 32'h3, "status write");
  endtask
  task automatic t_sleep(input logic gid);
    int n;
    logic tv;
    @(posedge sys_clk);
    global_int_disable <= gid;
    int_src <= '{flag: 10'h201, enable: 10'h202};
    instr(1'b1);
    chk("in sleep", 1, core_ctl.in_sleep);
    chk("osc driver", 0, core_ctl.osc_driver_en);
    chk("pd", 0, powerdown_flag);
    chk("to", 1, timeout_flag);
    repeat (20) @(posedge sys_clk);
    #1 chk("still asleep", 1, core_ctl.in_sleep);
    wake(10'h202, n, tv);
    chk("prompt wake", 1, n < 8);
    chk("vector", !gid, tv);
  endtask
  // The source is pending before sleep, so the wake follows one cycle after entry.
  task automatic t_pending();
    @(posedge sys_clk);
    global_int_disable <= 1'b1;
    int_src <= '{flag: 10'h008, enable: 10'h008};
    instr(1'b1);
    @(posedge sys_clk);
    #1 chk("immediate wake", 1, core_ctl.resume);
    chk("awake", 0, core_ctl.in_sleep);
    chk("no vector", 0, core_ctl.take_vector);
    chk("pd kept", 0, powerdown_flag);
    chk("to kept", 1, timeout_flag);
    @(posedge sys_clk);
    int_src <= '0;
  endtask
  task automatic t_xt();
    int n;
    logic tv;
    bus_wr(8'h04, 32'he);
    instr(1'b1);
    wake(10'h004, n, tv);
    chk("xt vector", 0, tv);
    chk("start-up wait", 1, n >= 1024 && n <= 1030);
    chk("no reset", 0, core_ctl.device_reset);
  endtask
  task automatic t_timer();
    int n;
    logic tv;
    bus_wr(8'h04, 32'h3);
    instr(1'b0);
    instr(1'b0);
    chk("to set", 1, timeout_flag);
    repeat (12) @(posedge sys_clk);
    #1 chk("to early", 1, timeout_flag);
    for (n = 0; n < 10 && timeout_flag !== 1'b0; n++) @(posedge sys_clk);
    #1 chk("to overflow", 0, timeout_flag);
    chk("no reset", 0, core_ctl.device_reset);
    instr(1'b0);
    instr(1'b1);
    repeat (40) @(posedge sys_clk);
    #1 chk("frozen", 1, timeout_flag);
    wake(10'h010, n, tv);
    repeat (14) @(posedge sys_clk);
    #1 chk("cleared", 1, timeout_flag);
  endtask
  task automatic t_wdt(input logic [1:0] ps, input int ratio);
    int n;
    int exp;
    exp = 16 * ratio * RCP;
    bus_wr(8'h04, {28'h0, ps, 2'h3});
    instr(1'b0);
    rc_run <= 1'b1;
    for (n = 0; n < 40000 && core_ctl.device_reset !== 1'b1; n++) @(posedge sys_clk);
    rc_run <= 1'b0;
    chk("overflow time", 1, n >= exp * 7 / 8 && n <= exp * 9 / 8 + 20);
    chk("mclr pin", 1, master_clear_n);
    #1 chk("to cleared", 0, timeout_flag);
    repeat (4) @(posedge sys_clk);
    instr(1'b0);
  endtask
  // External reset while asleep: a reset-type wake, then back to running.
  task automatic t_mclr();
    instr(1'b1);
    @(posedge sys_clk);
    mclr_level <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk("mclr reset", 1, core_ctl.device_reset);
    chk("mclr wake", 0, core_ctl.in_sleep);
    @(posedge sys_clk);
    mclr_level <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 chk("mclr release", 0, core_ctl.device_reset);
  endtask
  task automatic end_sim();
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    repeat (12) @(posedge sys_clk);
    chk("pd at reset", 1, powerdown_flag);
    reset_n <= 1'b1;
    t_powerup();
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_pending();
    t_xt();
    t_timer();
    t_wdt(2'h3, 1);
    t_wdt(2'h1, 64);
    t_wdt(2'h2, 256);
    t_mclr();
    end_sim();
  end
  initial begin
    #400000;
    fails++;
    end_sim();
  end
endmodule // tb
bind sleep_wake_watchdog_control swwd_checker #(.WDT_CNT_W(WDT_CNT_W)) chk_i (.sys_clk(sys_clk),
  .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data), .global_int_disable(global_int_disable),
  .master_clear_oe(master_clear_oe), .core_ctl(core_ctl), .timeout_flag(timeout_flag),
  .powerdown_flag(powerdown_flag));
`default_nettype wire
